// >>> logic/srpc_pin_pad_cfg.sv
/*
  Pad configuration register of one multipurpose pin: pull-up, slew, drive.
  Assumes the top decodes the address and supplies the soft reset level.
*/
`timescale 1ns/10ps
`default_nettype none

module srpc_pin_pad_cfg (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic wr_in,               // Write strobe, address already decoded
  input wire logic [15:0] wdata_in,     // Write data
  input wire logic soft_reset_in,       // High while the soft reset state holds
  output logic [15:0] value_out         // Stored register image
);
  import srpc_pkg::*;

  typedef struct packed {
    logic [15:0] value;  // Only bits 4..0 are storage
  } srpc_pin_state_type;

  srpc_pin_state_type state;       // Registered state
  srpc_pin_state_type next_state;  // Next state

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Soft reset wins over a write, so a write during soft reset is lost
  always_comb begin
    next_state = state;
    if (soft_reset_in) begin
      next_state.value = PIN_CFG_RESET;
    end else if (wr_in) begin
      next_state.value = 16'h0000;       // Reserved bits are read-only zero
      next_state.value[PIN_PULL_BIT] = wdata_in[PIN_PULL_BIT];
      next_state.value[PIN_SLEW_HI:PIN_SLEW_LO] = wdata_in[PIN_SLEW_HI:PIN_SLEW_LO];
      next_state.value[PIN_DRIVE_HI:PIN_DRIVE_LO] = wdata_in[PIN_DRIVE_HI:PIN_DRIVE_LO];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state.value <= PIN_CFG_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign value_out = state.value;

endmodule : srpc_pin_pad_cfg

`default_nettype wire

// >>> logic/srpc_pkg.sv
/*
  Constants shared by the soft reset and pin pad control block:
  register addresses, field positions and values after reset.
  Assumes 16-bit register addresses and data from the slave port front end.
*/
package srpc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PIN_CFG_ADDR = 16'hf7b9;    // Pad config of the multipurpose pin
  localparam logic [15:0] SOFT_RST_ADDR = 16'hf890;   // Soft reset control
  localparam logic [15:0] SYNTH_BASE_ADDR = 16'hf000; // First clock synthesizer register
  localparam logic [15:0] SYNTH_LAST_ADDR = 16'hf006; // Last clock synthesizer register
  localparam logic [15:0] PANIC_CFG_ADDR = 16'hf400;  // Fault manager setting
  localparam int SYNTH_COUNT = 7;                     // Registers in the synthesizer bank

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PIN_PULL_BIT = 4;  // Pull-up enable
  localparam int PIN_SLEW_HI = 3;   // Slew rate, upper bit
  localparam int PIN_SLEW_LO = 2;   // Slew rate, lower bit
  localparam int PIN_DRIVE_HI = 1;  // Drive strength, upper bit
  localparam int PIN_DRIVE_LO = 0;  // Drive strength, lower bit
  localparam int SOFT_RST_BIT = 0;  // Active-low soft reset bit

  // ----------------------------------------------------------------
  // Values after reset, and the read answer for unmapped addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PIN_CFG_RESET = 16'h0018;
  localparam logic [15:0] SOFT_RST_RESET = 16'h0001;
  localparam logic [15:0] SYNTH_RESET = 16'h0000;     // Plain default for each synth word
  localparam logic [15:0] PANIC_CFG_RESET = 16'h0000; // Plain default for the fault setting
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;   // Answer for unknown addresses

endpackage : srpc_pkg

// >>> logic/srpc_soft_reset_pin_control.sv
/*
  Soft reset control and multipurpose pin pad control, register side.
  Assumes an I2C/SPI slave front end that turns each transaction into a
  one-cycle read or write strobe with 16-bit address and data.
*/
`timescale 1ns/10ps
`default_nettype none

module srpc_soft_reset_pin_control (
  input wire logic ref_clk_in,
  input wire logic resetn_in,                // Hardware reset pin, active low
  input wire logic [15:0] reg_addr_in,       // Register address from slave port
  input wire logic [15:0] reg_wdata_in,      // Write data from slave port
  input wire logic reg_wr_in,                // One-cycle write strobe
  input wire logic reg_rd_in,                // One-cycle read strobe
  input wire logic spi_select_in,            // Pulse: front end saw SPI entry
  output logic [15:0] reg_rdata_out,         // Read data, registered
  output logic reg_ack_out,                  // One-cycle answer to a strobe
  output logic spi_mode_out,                 // High: control port in SPI mode
  output logic soft_reset_out,               // High: soft reset state, for other regs
  output logic pin_pullup_enable_out,        // Pull-up enable of the pin
  output logic [1:0] pin_slew_select_out,    // Slew rate of the pin
  output logic [1:0] pin_drive_select_out,   // Drive strength of the pin
  output logic [15:0] panic_cfg_out          // Fault manager setting
);
  import srpc_pkg::*;

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  // Shared by the write decode and the read mux
  function automatic logic in_synth_range(input logic [15:0] addr);
    in_synth_range = (addr >= SYNTH_BASE_ADDR) && (addr <= SYNTH_LAST_ADDR);
  endfunction : in_synth_range

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // All local state in one image, copied whole on each edge
  typedef struct packed {
    logic [15:0] soft_reg;  // Soft reset register image
    logic [15:0] panic;     // Fault manager setting
    logic spi_mode;         // Control port mode flag
    logic ack;              // Answer pulse
    logic [15:0] rdata;     // Read data
  } srpc_top_state_type;

  srpc_top_state_type state;       // Registered state
  srpc_top_state_type next_state;  // Next state

  logic soft_active;        // Soft reset state held
  logic wr_pin;             // Decoded write to pin register
  logic wr_synth;           // Decoded write to synth bank
  logic [15:0] pin_value;   // Pin register image
  logic [6:0][15:0] synth_words;  // Synth bank images

  // Level taken straight from the stored bit: it starts one edge after
  // the write and cannot glitch on a strobe
  assign soft_active = ~state.soft_reg[SOFT_RST_BIT];  // Active low bit
  assign wr_pin = reg_wr_in && (reg_addr_in == PIN_CFG_ADDR);
  assign wr_synth = reg_wr_in && in_synth_range(reg_addr_in);

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  // The only local register that the soft reset level forces
  srpc_pin_pad_cfg u_pin (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .wr_in(wr_pin),
    .wdata_in(reg_wdata_in),
    .soft_reset_in(soft_active),
    .value_out(pin_value)
  );

  // Bank has no soft reset input, so it cannot be disturbed
  srpc_synth_bank u_synth (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .wr_in(wr_synth),
    .index_in(reg_addr_in[2:0]),
    .wdata_in(reg_wdata_in),
    .words_out(synth_words)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Strobes are answered whatever the soft reset state, so the host
  // can always reach the soft reset bit again to leave it
  always_comb begin
    next_state = state;
    next_state.ack = reg_wr_in | reg_rd_in;  // Never gated
    // Mode flag only ever sets; cleared by the reset pin alone
    if (spi_select_in) begin
      next_state.spi_mode = 1'b1;
    end
    // Soft reset register, writable in both states
    if (reg_wr_in && (reg_addr_in == SOFT_RST_ADDR)) begin
      next_state.soft_reg = reg_wdata_in;
    end
    // Fault setting ignores the soft reset state
    if (reg_wr_in && (reg_addr_in == PANIC_CFG_ADDR)) begin
      next_state.panic = reg_wdata_in;
    end
    // Read mux, registered; rdata loads only on a read, so it stands
    // until the next one
    if (reg_rd_in) begin
      if (reg_addr_in == PIN_CFG_ADDR) begin
        next_state.rdata = pin_value;
      end else if (reg_addr_in == SOFT_RST_ADDR) begin
        next_state.rdata = state.soft_reg;
      end else if (reg_addr_in == PANIC_CFG_ADDR) begin
        next_state.rdata = state.panic;
      end else if (in_synth_range(reg_addr_in)) begin
        next_state.rdata = synth_words[reg_addr_in[2:0]];
      end else begin
        next_state.rdata = UNMAPPED_READ;  // Unknown address
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Hardware reset is the only path back to I2C mode
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state.soft_reg <= SOFT_RST_RESET;
      state.panic <= PANIC_CFG_RESET;
      state.spi_mode <= 1'b0;
      state.ack <= 1'b0;
      state.rdata <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out = state.rdata;
  assign reg_ack_out = state.ack;
  assign spi_mode_out = state.spi_mode;
  assign soft_reset_out = soft_active;  // Other control registers reset on this
  // Fields split out of the stored image; reserved bits never reach the pad
  assign pin_pullup_enable_out = pin_value[PIN_PULL_BIT];
  assign pin_slew_select_out = pin_value[PIN_SLEW_HI:PIN_SLEW_LO];
  assign pin_drive_select_out = pin_value[PIN_DRIVE_HI:PIN_DRIVE_LO];
  assign panic_cfg_out = state.panic;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // All checks run on the system clock and rest while the reset pin is
  // low, when every register is being forced anyway
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // Soft reset holds the pin register at its default
  property p_pin_default;
    soft_active |=> (pin_value == PIN_CFG_RESET);
  endproperty
  a_pin_default: assert property (p_pin_default)
    else $error("pin register not default during soft reset");

  // Synth bank is unchanged by soft reset when not written
  property p_synth_kept;
    (soft_active && !wr_synth) |=> $stable(synth_words);
  endproperty
  a_synth_kept: assert property (p_synth_kept)
    else $error("synth bank changed by soft reset");

  // Fault setting is unchanged by soft reset when not written
  property p_panic_kept;
    (soft_active && !(reg_wr_in && reg_addr_in == PANIC_CFG_ADDR)) |=> $stable(panic_cfg_out);
  endproperty
  a_panic_kept: assert property (p_panic_kept)
    else $error("fault setting changed by soft reset");

  // Every strobe is answered one cycle later, soft reset or not
  property p_ack;
    (reg_wr_in || reg_rd_in) |=> reg_ack_out;
  endproperty
  a_ack: assert property (p_ack)
    else $error("strobe not answered");

  // A write to the first synth word (SYNTH_BASE_ADDR) during soft reset is stored
  property p_synth_write;
    (soft_active && reg_wr_in && reg_addr_in == SYNTH_BASE_ADDR)
      |=> (synth_words[0] == $past(reg_wdata_in));
  endproperty
  a_synth_write: assert property (p_synth_write)
    else $error("synth write lost during soft reset");

  // SPI mode never drops without the reset pin
  property p_spi_sticky;
    spi_mode_out |=> spi_mode_out [*2];
  endproperty
  a_spi_sticky: assert property (p_spi_sticky)
    else $error("spi mode dropped");

  // Soft reset cannot switch the mode either way
  property p_mode_no_change;
    (soft_active && !spi_select_in) |=> (spi_mode_out == $past(spi_mode_out));
  endproperty
  a_mode_no_change: assert property (p_mode_no_change)
    else $error("mode changed by soft reset");

  // Writing bit 0 low enters soft reset, and it shows on the output
  property p_enter;
    (reg_wr_in && reg_addr_in == SOFT_RST_ADDR && !reg_wdata_in[SOFT_RST_BIT])
      |=> soft_reset_out ##1 (pin_value == PIN_CFG_RESET);
  endproperty
  a_enter: assert property (p_enter)
    else $error("soft reset not entered");

  // Normal-state pin writes land in the fields
  property p_pin_write;
    (wr_pin && !soft_active) |=> (pin_value == {11'h000, $past(reg_wdata_in[4:0])});
  endproperty
  a_pin_write: assert property (p_pin_write)
    else $error("pin field write wrong");

  // Reserved pin bits never hold a one
  property p_pin_reserved;
    pin_value[15:5] == 11'h000;
  endproperty
  a_pin_reserved: assert property (p_pin_reserved)
    else $error("pin reserved bits not zero");

  // Outside soft reset the pin register moves only on its own write
  property p_pin_kept;
    (!soft_active && !wr_pin) |=> $stable(pin_value);
  endproperty
  a_pin_kept: assert property (p_pin_kept)
    else $error("pin register changed without a write");

  // Writing bit 0 high selects normal operation on the next edge
  property p_leave;
    (reg_wr_in && reg_addr_in == SOFT_RST_ADDR && reg_wdata_in[SOFT_RST_BIT])
      |=> !soft_reset_out;
  endproperty
  a_leave: assert property (p_leave)
    else $error("soft reset not left");

  // Soft reset stays until the host writes the bit back
  property p_soft_kept;
    (soft_active && !(reg_wr_in && reg_addr_in == SOFT_RST_ADDR)) |=> soft_reset_out;
  endproperty
  a_soft_kept: assert property (p_soft_kept)
    else $error("soft reset left without a write");

  // A fault setting write lands on the next edge, soft reset or not
  property p_panic_write;
    (reg_wr_in && reg_addr_in == PANIC_CFG_ADDR)
      |=> (panic_cfg_out == $past(reg_wdata_in));
  endproperty
  a_panic_write: assert property (p_panic_write)
    else $error("fault setting write lost");

  // No strobe, no answer: a stray ack would be taken as a transfer
  property p_ack_only;
    !(reg_wr_in || reg_rd_in) |=> !reg_ack_out;
  endproperty
  a_ack_only: assert property (p_ack_only)
    else $error("answer without a strobe");

  // Read data holds between reads
  property p_rdata_hold;
    !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");

  // The front end's entry pulse switches to SPI on the next edge
  property p_spi_set;
    spi_select_in |=> spi_mode_out;
  endproperty
  a_spi_set: assert property (p_spi_set)
    else $error("spi mode not entered");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  // Main scenarios the bench is meant to reach
  c_enter_exit: cover property (soft_reset_out ##[1:20] !soft_reset_out);
  c_synth_in_soft: cover property (soft_active && wr_synth);
  c_spi_in_soft: cover property (spi_mode_out && soft_active);
  c_pin_dropped: cover property (wr_pin && soft_active);  // Pin write lost
  c_pin_written: cover property (wr_pin && !soft_active);

endmodule : srpc_soft_reset_pin_control

`default_nettype wire

// >>> logic/srpc_synth_bank.sv
/*
  Clock synthesizer register bank, seven words, kept across soft reset.
  Assumes the top gives a decoded write strobe and a word index.
*/
`timescale 1ns/10ps
`default_nettype none

module srpc_synth_bank (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic wr_in,                // Write strobe for the bank
  input wire logic [2:0] index_in,       // Word index inside the bank
  input wire logic [15:0] wdata_in,      // Write data
  output logic [6:0][15:0] words_out     // All stored words
);
  import srpc_pkg::*;

  typedef struct packed {
    logic [6:0][15:0] words;  // Storage, addressed by index
  } srpc_synth_state_type;

  srpc_synth_state_type state;       // Registered state
  srpc_synth_state_type next_state;  // Next state

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // No soft reset input at all: the bank cannot be disturbed by it
  always_comb begin
    next_state = state;
    if (wr_in && (int'(index_in) < SYNTH_COUNT)) begin
      next_state.words[index_in] = wdata_in;  // Accepted in any state
    end
  end

  // ----------------------------------------------------------------
  // State register, hardware reset only
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state.words <= {SYNTH_COUNT{SYNTH_RESET}};
    end else begin
      state <= next_state;
    end
  end

  assign words_out = state.words;

endmodule : srpc_synth_bank

`default_nettype wire

// >>> tb/srpc_host_model.sv
/*
  Host controller model on the register strobe port of the soft reset and
  pin pad control block.
  Assumes the block answers every strobe with a one-cycle ack one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none

module srpc_host_model (
  input wire logic ref_clk_in,
  input wire logic reg_ack_in,           // Answer pulse from the block
  input wire logic [15:0] reg_rdata_in,  // Read data from the block
  output logic [15:0] reg_addr_out,      // Register address
  output logic [15:0] reg_wdata_out,     // Write data
  output logic reg_wr_out,               // Write strobe
  output logic reg_rd_out                // Read strobe
);
  // ----------------------------------------------------------------
  // Idle bus from time zero
  // ----------------------------------------------------------------
  initial begin
    reg_addr_out = 16'h0000;
    reg_wdata_out = 16'h0000;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  // One access: strobe held for one edge, then released
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
      output logic [15:0] rdata, output logic ack);
    @(posedge ref_clk_in);
    #1;
    reg_wr_out = wr;
    reg_rd_out = !wr;
    reg_addr_out = addr;
    reg_wdata_out = data;
    @(posedge ref_clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    // Released lines show the inverse, so a stale value cannot pass
    reg_addr_out = ~addr;
    reg_wdata_out = ~data;
    // Ack stands one cycle only, so it is taken now
    rdata = reg_rdata_in;
    ack = reg_ack_in;
  endtask : access

endmodule : srpc_host_model
`default_nettype wire

// >>> tb/srpc_soft_reset_pin_control_bench.sv
/*
  Self-checking bench for the soft reset and pin pad control block.
  Assumes the host model file is compiled before this one.
*/
`timescale 1ns/10ps
`default_nettype none

module srpc_soft_reset_pin_control_bench;
  import srpc_pkg::*;

  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic spi_select_in = 1'b0;
  logic [15:0] addr, wdata, rdata, panic;
  logic wr, rd, ack, spi, srst, pull;
  logic [1:0] slew, drive;
  int bad_count = 0;
  int num_checks = 0;
  int m_synth[7];           // Model of the synthesizer words
  int m_pin, m_srst, m_panic, m_spi;
  logic [15:0] alist[13] = '{16'hf7b9, 16'hf890, 16'hf400, 16'hf007, 16'hefff, 16'hf000,
      16'hf001, 16'hf002, 16'hf003, 16'hf004, 16'hf005, 16'hf006, 16'hf7b8};

  // 125 MHz clock
  always #4 ref_clk_in = ~ref_clk_in;

  srpc_soft_reset_pin_control dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .spi_select_in(spi_select_in), .reg_rdata_out(rdata), .reg_ack_out(ack),
      .spi_mode_out(spi), .soft_reset_out(srst), .pin_pullup_enable_out(pull),
      .pin_slew_select_out(slew), .pin_drive_select_out(drive), .panic_cfg_out(panic));

  srpc_host_model host (.ref_clk_in(ref_clk_in), .reg_ack_in(ack), .reg_rdata_in(rdata),
      .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic void model_reset();
    m_pin = 'h18;
    m_srst = 'h1;
    m_panic = 0;
    m_spi = 0;
    foreach (m_synth[k]) m_synth[k] = 0;
  endfunction : model_reset

  function automatic int model_read(input int a);
    if (a == 'hf7b9) return m_pin;
    if (a == 'hf890) return m_srst;
    if (a == 'hf400) return m_panic;
    if (a >= 'hf000 && a <= 'hf006) return m_synth[a - 'hf000];
    return 0;
  endfunction : model_read

  // Pin writes are lost while soft reset holds; upper pin bits read 0
  function automatic void model_write(input int a, input int d);
    if (a == 'hf7b9 && m_srst[0]) m_pin = d & 'h1f;
    if (a == 'hf400) m_panic = d;
    if (a >= 'hf000 && a <= 'hf006) m_synth[a - 'hf000] = d;
    if (a == 'hf890) begin
      m_srst = d;
      if (!d[0]) m_pin = 'h18;
    end
  endfunction : model_write

  // ----------------------------------------------------------------
  // Checking and access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // One access, then the port levels one cycle after the answer
  task automatic op(input logic w, input logic [15:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic k;
    host.access(w, a, d, r, k);
    check({15'h0000, k}, 16'h0001);
    if (!w) check(r, 16'(model_read(a)));
    else model_write(a, d);
    @(posedge ref_clk_in);
    #1;
    check({11'h000, pull, slew, drive}, 16'(m_pin));
    check({14'h0000, srst, spi}, {14'h0000, !m_srst[0], m_spi[0]});
    check(panic, 16'(m_panic));
  endtask : op

  // Hardware reset held for six cycles
  task automatic hw_reset();
    resetn_in = 1'b0;
    repeat (6) @(posedge ref_clk_in);
    #1;
    resetn_in = 1'b1;
    model_reset();
  endtask : hw_reset

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(60));
    hw_reset();
    // Values after reset, unmapped places included
    foreach (alist[k]) op(1'b0, alist[k], 16'h0000);
    // Random traffic, soft reset register among the targets
    repeat (150) op(1'($urandom), alist[$urandom % 13], 16'($urandom));
    op(1'b1, 16'hf890, 16'h0001);
    // Every pull, slew and drive code, with junk in the upper bits
    for (int k = 0; k < 32; k++) begin
      op(1'b1, 16'hf7b9, (16'($urandom) & 16'hffe0) | 16'(k));
      op(1'b0, 16'hf7b9, 16'h0000);
    end
    op(1'b1, 16'hf400, 16'hbeef);
    op(1'b1, 16'hf003, 16'h1234);
    // Port enters SPI mode before the soft reset
    @(posedge ref_clk_in);
    #1;
    spi_select_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    spi_select_in = 1'b0;
    m_spi = 1;
    op(1'b1, 16'hf890, 16'h0000);
    op(1'b1, 16'hf7b9, 16'h001f);
    for (int k = 0; k < 7; k++) begin
      op(1'b1, 16'hf000 + 16'(k), 16'($urandom));
      op(1'b0, 16'hf000 + 16'(k), 16'h0000);
    end
    op(1'b0, 16'hf400, 16'h0000);
    op(1'b0, 16'hf890, 16'h0000);
    // Host leaves soft reset; pin keeps its default until rewritten
    op(1'b1, 16'hf890, 16'h0001);
    op(1'b0, 16'hf7b9, 16'h0000);
    op(1'b1, 16'hf7b9, 16'h0016);
    // Only the reset pin brings back I2C mode and clears the synth words
    hw_reset();
    foreach (alist[k]) op(1'b0, alist[k], 16'h0000);
    give_verdict();
  end

  // Watchdog far beyond the expected run of under a thousand cycles
  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end

endmodule : srpc_soft_reset_pin_control_bench
`default_nettype wire
